// file: bench/wsg_mem_model.sv
/* wsg_mem_model: memory on the external parallel bus.
   assumes: ready low for stall_i strobe cycles, data toggles when unread. */
`timescale 1ns/1ns
module wsg_mem_model (
   input  wire logic        mclk_i,
   input  wire logic        rd_n_i,
   input  wire logic        wr_n_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic [3:0]  stall_i,
   output logic [15:0]      data_o,
   output logic             ready_o
);
   logic [15:0] mem [16];
   logic [15:0] junk = 16'h5a5a;
   logic [3:0]  cnt = 4'h0;
   assign ready_o = (cnt >= stall_i);
   // released bus toggles so a stale value never passes
   assign data_o = rd_n_i ? junk : mem[addr_i[3:0]];
   always @(posedge mclk_i) begin
      junk <= ~junk;
      cnt <= (rd_n_i & wr_n_i) ? 4'h0 : cnt + 4'(cnt != 4'hf);
      if (!wr_n_i) mem[addr_i[3:0]] <= wdata_i;
   end
endmodule

// file: bench/wsg_wait_state_generator_test.sv
/* wsg_wait_state_generator_test: self-checking bench.
   assumes: wsg_mem_model answers on the external pins. */
`timescale 1ns/1ns
module wsg_wait_state_generator_test;
   import wsg_pkg::*;
   logic        mclk_i = 1'b0;
   logic        arst_n_i = 1'b0;
   wsg_req_s    req = '0;
   logic [15:0] pa = 16'h0000;
   logic [3:0]  stall = 4'h0;
   logic        busy, done, oe, rdy, rd_n, wr_n, bv, ov;
   logic [15:0] rdata, eaddr, edo, edi;
   logic [3:0]  ctrl;
   logic [2:0]  sel_n, sv;
   logic [3:0]  cset [3] = '{4'h0, 4'h7, 4'h8};
   int          fail_count = 0;
   int          n_tests = 0;
   int          lat, wrc;
   wsg_wait_state_generator wsg_wait_state_generator_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
      .req_i(req), .prog_addr_i(pa), .busy_o(busy), .done_o(done), .rdata_o(rdata),
      .ctrl_o(ctrl), .ext_addr_o(eaddr), .ext_data_o(edo), .ext_data_oe_o(oe),
      .ext_data_i(edi), .ext_ready_i(rdy), .ext_rd_n_o(rd_n), .ext_wr_n_o(wr_n),
      .ext_sel_n_o(sel_n));
   wsg_mem_model wsg_mem_model_i (.mclk_i(mclk_i), .rd_n_i(rd_n), .wr_n_i(wr_n),
      .addr_i(eaddr), .wdata_i(edo), .stall_i(stall), .data_o(edi), .ready_o(rdy));
   initial begin
      forever #20 mclk_i = ~mclk_i;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one access; lat counts negedges to done, wrc those with the write strobe low;
   // sv, bv and ov keep the select, busy and output enable of the first cycle
   task automatic acc(input logic w, input logic [1:0] sp, input logic [15:0] a, input logic [15:0] d);
      @(negedge mclk_i);
      req = '{1'b1, w, sp, a, d};
      lat = 0;
      wrc = 0;
      do begin
         @(negedge mclk_i);
         lat++;
         wrc += int'(wr_n === 1'b0);
         if (lat == 1) begin
            sv = sel_n;
            bv = busy;
            ov = oe;
         end
      end while (done !== 1'b1 && lat < 60);
      req.valid = 1'b0;
   endtask
   task automatic t_reg;
      check({12'h000, ctrl}, 16'h000f);
      acc(1'b0, WSG_SP_IO, WSG_CTRL_ADDR, 16'h0000);
      check(rdata, 16'h000f);
      check(16'(lat), 16'h0001);
      acc(1'b1, WSG_SP_IO, WSG_CTRL_ADDR, 16'hfff5);
      check({12'h000, ctrl}, 16'h0005);
      acc(1'b0, WSG_SP_IO, WSG_CTRL_ADDR, 16'h0000);
      check(rdata, 16'h0005);
      $display("register test done");
   endtask
   task automatic t_waits;
      acc(1'b1, WSG_SP_PROG, 16'h0001, 16'hc3a5);
      for (int c = 0; c < 3; c++) begin
         acc(1'b1, WSG_SP_IO, WSG_CTRL_ADDR, {12'h000, cset[c]});
         for (int s = 0; s < 3; s++) begin
            acc(1'b0, 2'(s), 16'h0001, 16'h0000);
            // two sync clocks before data is taken; an inserted wait costs one more, trace mode none
            check(16'(lat), 16'h0004 + 16'(cset[c][s]));
            check(rdata, 16'hc3a5);
            check({12'h000, bv, sv}, {12'h000, 1'b1, 3'h7 ^ 3'(1 << s)});
         end
      end
      $display("wait state test done");
   endtask
   task automatic t_write;
      acc(1'b1, WSG_SP_IO, WSG_CTRL_ADDR, 16'h0000);
      acc(1'b1, WSG_SP_DATA, 16'h0002, 16'ha5c3);
      check(16'(wrc), 16'h0002);
      check(16'(lat), 16'h0003);
      check({15'h0000, ov}, 16'h0001);
      check(edo, 16'ha5c3);
      stall = 4'h4;
      acc(1'b0, WSG_SP_DATA, 16'h0002, 16'h0000);
      check(rdata, 16'ha5c3);
      check(16'(lat), 16'h0008);
      stall = 4'h0;
      $display("write and stall test done");
   endtask
   task automatic t_trace;
      acc(1'b1, WSG_SP_IO, WSG_CTRL_ADDR, 16'h0008);
      pa = 16'h1234;
      repeat (4) @(negedge mclk_i);
      check(eaddr, 16'h1234);
      acc(1'b1, WSG_SP_IO, WSG_CTRL_ADDR, 16'h0000);
      pa = 16'h4321;
      repeat (4) @(negedge mclk_i);
      check(eaddr, 16'h1234);
      $display("trace test done");
   endtask
   task automatic t_reset;
      @(negedge mclk_i);
      arst_n_i = 1'b0;
      repeat (3) @(negedge mclk_i);
      check({12'h000, ctrl}, 16'h000f);
      arst_n_i = 1'b1;
      acc(1'b0, WSG_SP_DATA, 16'h0002, 16'h0000);
      check(16'(lat), 16'h0005);
      check(rdata, 16'ha5c3);
      $display("reset test done");
   endtask
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge mclk_i);
      arst_n_i = 1'b1;
      t_reg();
      t_waits();
      t_write();
      t_trace();
      t_reset();
      finish_test();
   end
   // watchdog far beyond the roughly 120 cycles the tests need
   initial begin
      #400000;
      fail_count++;
      finish_test();
   end
endmodule

// file: rtl/wsg_pkg.sv
/*
 * wsg_pkg: constants, request carrier and state record of the wait-state generator.
 * assumes: a single cpu output clock domain and one outstanding bus access at a time.
 */
package wsg_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [15:0] WSG_CTRL_ADDR   = 16'hFFFF;
   localparam int          WSG_CTRL_BITS   = 4;
   localparam logic [3:0]  WSG_CTRL_RESET  = 4'hF;
   localparam int          WSG_BIT_PROG    = 0;
   localparam int          WSG_BIT_DATA    = 1;
   localparam int          WSG_BIT_IO      = 2;
   localparam int          WSG_BIT_TRACE   = 3;
   localparam int          WSG_DATA_W      = 16;

   // ****************************************************************
   // memory spaces, coded as the index of their wait bit and select
   // ****************************************************************
   localparam logic [1:0]  WSG_SP_PROG     = 2'h0;
   localparam logic [1:0]  WSG_SP_DATA     = 2'h1;
   localparam logic [1:0]  WSG_SP_IO       = 2'h2;
   localparam logic [2:0]  WSG_SEL_NONE    = 3'h7;
   // clocks a read counts in transfer before it may end, so that both pin synchroniser stages see the strobed bus
   localparam logic [1:0]  WSG_SYNC_CLKS   = 2'h2;

   typedef enum logic [1:0] {
      WSG_IDLE,
      WSG_WAIT,
      WSG_XFER
   } wsg_phase_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  space;
      logic [15:0] addr;
      logic [15:0] wdata;
   } wsg_req_s;

   typedef struct packed {
      wsg_phase_e  phase;
      logic [3:0]  ctrl;
      logic        rdy_m;
      logic        rdy_s;
      logic [15:0] din_m;
      logic [15:0] din_s;
      logic [15:0] addr;
      logic [15:0] dout;
      logic        doe;
      logic        rd_n;
      logic        wr_n;
      logic [2:0]  sel_n;
      logic        write;
      logic        done;
      logic        busy;
      logic [1:0]  settle;
      logic [15:0] rdata;
   } wsg_state_s;

endpackage

// file: rtl/wsg_wait_state_generator.sv
/*
 * wsg_wait_state_generator: external bus sequencer with a per-space wait-state
 * generator, an external ready stretch and program address tracing on the idle bus.
 * assumes: the cpu holds req_i stable while busy_o is high; ready and read data pins
 * are asynchronous and pass two flip-flops; the wait_state_control register sits in
 * i/o space and is never forwarded to the pins.
 * a read ends three clocks into its transfer phase at the earliest: data and ready
 * are seen through two flip-flops, so an earlier end would return a stale word.
 */
// How it works
// - wait bit set inserts one wait on every external read of its space; writes always get one
// - low ready stretches access any number cycles
// - generator adds only zero or one wait
// - reset sets all control bits to one
// - every external write lasts two clocks while ready is high
// - control register read/write at top i/o address
// - upper twelve control bits read as zero
// - trace program address on idle bus
// - trace mode adds no wait state
// - i/o bit gives one wait on reads
// - data bit gives one wait on reads
// - program bit gives one wait on reads
`timescale 1ns/1ns
module wsg_wait_state_generator
   import wsg_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        arst_n_i,
   input  wire wsg_req_s    req_i,
   input  wire logic [15:0] prog_addr_i,
   output logic             busy_o,
   output logic             done_o,
   output logic [15:0]      rdata_o,
   output logic [3:0]       ctrl_o,
   output logic [15:0]      ext_addr_o,
   output logic [15:0]      ext_data_o,
   output logic             ext_data_oe_o,
   input  wire logic [15:0] ext_data_i,
   input  wire logic        ext_ready_i,
   output logic             ext_rd_n_o,
   output logic             ext_wr_n_o,
   output logic [2:0]       ext_sel_n_o
);

   // ****************************************************************
   // state
   // ****************************************************************
   wsg_state_s st_r;
   wsg_state_s st_nxt;

   logic       take;
   logic       reg_hit;
   logic       need_wait;

   assign take      = req_i.valid && (st_r.phase == WSG_IDLE) && !st_r.busy;
   assign reg_hit   = (req_i.space == WSG_SP_IO) && (req_i.addr == WSG_CTRL_ADDR);
   // writes always get the extra clock; reads only when their space bit asks
   assign need_wait = req_i.write || st_r.ctrl[req_i.space];

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      st_nxt       = st_r;
      // only the second stage of each synchroniser is read below
      st_nxt.rdy_m = ext_ready_i;
      st_nxt.rdy_s = st_r.rdy_m;
      st_nxt.din_m = ext_data_i;
      st_nxt.din_s = st_r.din_m;
      st_nxt.done  = 1'b0;
      case (st_r.phase)
         WSG_IDLE: begin
            st_nxt.busy  = 1'b0;
            st_nxt.doe   = 1'b0;
            st_nxt.rd_n  = 1'b1;
            st_nxt.wr_n  = 1'b1;
            st_nxt.sel_n = WSG_SEL_NONE;
            if (st_r.ctrl[WSG_BIT_TRACE]) begin
               st_nxt.addr = prog_addr_i;
            end
            if (take && reg_hit) begin
               st_nxt.done = 1'b1;
               if (req_i.write) begin
                  st_nxt.ctrl = req_i.wdata[WSG_CTRL_BITS-1:0];
               end
               st_nxt.rdata = {{(WSG_DATA_W-WSG_CTRL_BITS){1'b0}}, st_r.ctrl};
            end else if (take) begin
               st_nxt.busy               = 1'b1;
               st_nxt.addr               = req_i.addr;
               st_nxt.dout               = req_i.wdata;
               st_nxt.write              = req_i.write;
               st_nxt.doe                = req_i.write;
               st_nxt.rd_n               = req_i.write;
               st_nxt.wr_n               = !req_i.write;
               st_nxt.sel_n              = WSG_SEL_NONE;
               st_nxt.sel_n[req_i.space] = 1'b0;
               st_nxt.settle             = '0;
               // trace bit is not part of need_wait
               st_nxt.phase = need_wait ? WSG_WAIT : WSG_XFER;
            end
         end
         WSG_WAIT: begin
            st_nxt.phase = WSG_XFER;
         end
         WSG_XFER: begin
            // a read waits until both synchroniser stages hold bus values from inside the
            // transfer phase; a write drives the bus itself and ends on the first clock its synchronised ready is high
            if (st_r.settle != WSG_SYNC_CLKS) begin
               st_nxt.settle = st_r.settle + 2'h1;
            end
            if (st_r.rdy_s && (st_r.write || (st_r.settle == WSG_SYNC_CLKS))) begin
               st_nxt.phase = WSG_IDLE;
               st_nxt.done  = 1'b1;
               st_nxt.busy  = 1'b0;
               st_nxt.doe   = 1'b0;
               st_nxt.rd_n  = 1'b1;
               st_nxt.wr_n  = 1'b1;
               st_nxt.sel_n = WSG_SEL_NONE;
               if (!st_r.write) begin
                  st_nxt.rdata = st_r.din_s;
               end
            end
         end
         default: begin
            st_nxt.phase = WSG_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r       <= '0;
         st_r.phase <= WSG_IDLE;
         st_r.ctrl  <= WSG_CTRL_RESET;
         st_r.rd_n  <= 1'b1;
         st_r.wr_n  <= 1'b1;
         st_r.sel_n <= WSG_SEL_NONE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy_o        = st_r.busy;
   assign done_o        = st_r.done;
   assign rdata_o       = st_r.rdata;
   assign ctrl_o        = st_r.ctrl;
   assign ext_addr_o    = st_r.addr;
   assign ext_data_o    = st_r.dout;
   assign ext_data_oe_o = st_r.doe;
   assign ext_rd_n_o    = st_r.rd_n;
   assign ext_wr_n_o    = st_r.wr_n;
   assign ext_sel_n_o   = st_r.sel_n;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_ext_take;
      take && !reg_hit;
   endsequence
   sequence s_read_waited;
      s_ext_take and (!req_i.write && st_r.ctrl[req_i.space]);
   endsequence
   sequence s_read_fast;
      s_ext_take and (!req_i.write && !st_r.ctrl[req_i.space]);
   endsequence
   sequence s_write_take;
      s_ext_take and req_i.write;
   endsequence
   // the sync lag is the price of treating the bus pins as asynchronous
   sequence s_fast_settled;
      s_read_fast ##3 st_r.rdy_s;
   endsequence
   sequence s_write_settled;
      s_write_take ##2 st_r.rdy_s;
   endsequence
   sequence s_read_unsettled;
      st_r.phase == WSG_XFER && !st_r.write && st_r.settle != WSG_SYNC_CLKS;
   endsequence

   chk_wait_bit_read: assert property (s_read_waited |=> !done_o ##1 !done_o ##1 (st_r.phase == WSG_XFER))
      else $error("waited read did not hold one wait clock");
   chk_ready_stretch: assert property ((st_r.phase == WSG_XFER && !st_r.rdy_s) |=> (st_r.phase == WSG_XFER && !done_o))
      else $error("access ended while ready was low");
   chk_one_wait_max: assert property ((st_r.phase == WSG_WAIT) |=> (st_r.phase == WSG_XFER))
      else $error("internal wait lasted more than one clock");
   chk_reset_ctrl: assert property (!$past(arst_n_i) |-> ctrl_o == WSG_CTRL_RESET)
      else $error("control bits not all one after reset");
   chk_write_two_clk: assert property (s_write_take |=> (!ext_wr_n_o && !done_o)[*2])
      else $error("external write shorter than two clocks");
   chk_reg_write: assert property ((take && reg_hit && req_i.write) |=> ctrl_o == $past(req_i.wdata[3:0]) && done_o)
      else $error("control register write not stored");
   chk_reserved_zero: assert property (done_o && $past(take && reg_hit) |-> rdata_o[15:4] == 12'h000)
      else $error("reserved control bits read nonzero");
   chk_trace_addr: assert property ((st_r.phase == WSG_IDLE && !take && ctrl_o[WSG_BIT_TRACE]) |=> ext_addr_o == $past(prog_addr_i))
      else $error("program address not traced on idle bus");
   chk_fast_read: assert property (s_fast_settled |=> done_o)
      else $error("read without wait bit was delayed");
   chk_io_wait: assert property (s_read_waited and (req_i.space == WSG_SP_IO) |=> st_r.phase == WSG_WAIT)
      else $error("io read missed its wait state");

   // reads may not end before both synchroniser stages have settled
   chk_read_settle: assert property (s_read_unsettled |=> !done_o)
      else $error("read ended before the synchronisers settled");
   chk_fast_no_wait: assert property (s_read_fast |=> st_r.phase == WSG_XFER)
      else $error("read without wait bit entered a wait state");
   chk_data_wait: assert property (s_read_waited and (req_i.space == WSG_SP_DATA) |=> st_r.phase == WSG_WAIT)
      else $error("data read missed its wait state");
   chk_prog_wait: assert property (s_read_waited and (req_i.space == WSG_SP_PROG) |=> st_r.phase == WSG_WAIT)
      else $error("program read missed its wait state");
   chk_write_end: assert property (s_write_settled |=> done_o && ext_wr_n_o)
      else $error("external write longer than two clocks");
   chk_ctrl_hold: assert property (!(take && reg_hit && req_i.write) |=> $stable(ctrl_o))
      else $error("control bits changed without a register write");
   // strobes idle is what lets the trace address use the bus
   chk_bus_idle: assert property ((st_r.phase == WSG_IDLE) |-> &{ext_rd_n_o, ext_wr_n_o, ext_sel_n_o})
      else $error("bus strobes active while idle");

endmodule
